// File: shared/ccs_consts.svh
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// opcode fields
`define CCS_COMP_OPC     6'h07
`define CCS_CPEQ_OPC     7'h31
`define CCS_CPGT_OPC     7'h32
`define CCS_CPLT_OPC     7'h30

// field positions
`define CCS_DEST_BIT     9
`define CCS_ACC_BIT      8

// addressing
`define CCS_IDX_LIMIT    8'h5f
`define CCS_ACC_SPLIT    8'h60
`define CCS_ACC_LOW_BANK 4'h0
`define CCS_ACC_HI_BANK  4'hf

// phases of one instruction cycle
`define CCS_Q_DECODE     2'h0
`define CCS_Q_READ       2'h1
`define CCS_Q_PROCESS    2'h2
`define CCS_Q_WRITE      2'h3

// skip lengths and reset values
`define CCS_SKIP_ONE     2'h1
`define CCS_SKIP_TWO     2'h2
`define CCS_SKIP_NONE    2'h0
`define CCS_ADDR_RESET   12'h000
`define CCS_DATA_RESET   8'h00

`endif

// File: shared/ccs_pkg.sv
package ccs_pkg;

  typedef enum logic [2:0] {
    op_none,
    complement_register_op,
    compare_skip_equal_op,
    compare_skip_greater_op,
    compare_skip_less_op
  } ccs_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_skip
  } ccs_state_t;

  typedef struct packed {
    ccs_op_t    op;
    logic       dest;
    logic       access;
    logic [7:0] field;
  } ccs_decode_t;

  typedef struct packed {
    logic wr;
    logic n;
    logic z;
  } ccs_flags_t;

endpackage

// File: logic/ccs_addr_resolve.sv
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_addr_resolve (
  input  wire logic [7:0]  field,
  input  wire logic        access,
  input  wire logic        ext_enable,
  input  wire logic [3:0]  bank_pointer_register,
  input  wire logic [11:0] index_base,
  output logic      [11:0] addr,
  output logic             indexed
);

  always_comb begin
    indexed = !access && ext_enable && (field <= `CCS_IDX_LIMIT);
    if (access) begin
      addr = {bank_pointer_register, field};
    end else if (indexed) begin
      addr = 12'(index_base + {4'h0, field});
    end else if (field < `CCS_ACC_SPLIT) begin
      addr = {`CCS_ACC_LOW_BANK, field};
    end else begin
      addr = {`CCS_ACC_HI_BANK, field};
    end
  end

endmodule

// File: logic/ccs_exec.sv
// Operation
// - complement op inverts selected register
// - dest bit 0 to working, 1 to register
// - access bit 0 access bank, 1 bank pointer
// - indexed offset when a=0, extended, f<=95
// - equal compare unsigned, flags left unchanged
// - equal skips next: one nop cycle
// - skip over two-word instruction: two nops
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_exec (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr,
  input  wire logic                next_two_word,
  input  wire logic                ext_set_enable,
  input  wire logic [3:0]          bank_pointer_register,
  input  wire logic [11:0]         index_base,
  input  wire logic [7:0]          wreg_in,
  input  wire logic [7:0]          mem_rdata,
  output logic      [1:0]          q_phase,
  output logic      [11:0]         mem_addr,
  output logic                     mem_rd,
  output logic                     mem_wr,
  output logic                     wreg_wr,
  output logic      [7:0]          result,
  output ccs_pkg::ccs_flags_t      flags,
  output logic                     nop_cycle,
  output logic                     indexed_mode
);

  logic [1:0]           q;
  logic [1:0]           skip_left;
  ccs_pkg::ccs_state_t  state;
  ccs_pkg::ccs_decode_t cur;
  ccs_pkg::ccs_decode_t dec;
  logic [11:0]          res_addr;
  logic                 res_indexed;
  logic                 take_skip;

  function automatic ccs_pkg::ccs_decode_t decode(input logic [15:0] w);
    ccs_pkg::ccs_decode_t d;
    d.dest   = w[`CCS_DEST_BIT];
    d.access = w[`CCS_ACC_BIT];
    d.field  = w[7:0];
    if (w[15:10] == `CCS_COMP_OPC) begin
      d.op = ccs_pkg::complement_register_op;
    end else if (w[15:9] == `CCS_CPEQ_OPC) begin
      d.op = ccs_pkg::compare_skip_equal_op;
    end else if (w[15:9] == `CCS_CPGT_OPC) begin
      d.op = ccs_pkg::compare_skip_greater_op;
    end else if (w[15:9] == `CCS_CPLT_OPC) begin
      d.op = ccs_pkg::compare_skip_less_op;
    end else begin
      d.op = ccs_pkg::op_none;
    end
    return d;
  endfunction

  assign dec     = decode(instr);
  assign q_phase = q;

  ccs_addr_resolve ccs_addr_resolve_i (
    .field                 (cur.field),
    .access                (cur.access),
    .ext_enable            (ext_set_enable),
    .bank_pointer_register (bank_pointer_register),
    .index_base            (index_base),
    .addr                  (res_addr),
    .indexed               (res_indexed)
  );

  // unsigned compare outcome
  always_comb begin
    unique case (cur.op)
      ccs_pkg::compare_skip_equal_op:   take_skip = (mem_rdata == wreg_in);
      ccs_pkg::compare_skip_greater_op: take_skip = (mem_rdata > wreg_in);
      ccs_pkg::compare_skip_less_op:    take_skip = (mem_rdata < wreg_in);
      default:                          take_skip = 1'b0;
    endcase
  end

  // q phase divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= `CCS_Q_DECODE;
    end else begin
      q <= 2'(q + 2'h1);
    end
  end

  // decode and skip sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= ccs_pkg::st_idle;
      cur       <= '0;
      skip_left <= `CCS_SKIP_NONE;
      nop_cycle <= 1'b0;
    end else if (q == `CCS_Q_DECODE) begin
      if (skip_left != `CCS_SKIP_NONE) begin
        state     <= ccs_pkg::st_skip;
        skip_left <= 2'(skip_left - 2'h1);
        nop_cycle <= 1'b1;
      end else begin
        nop_cycle <= 1'b0;
        if (instr_valid && dec.op != ccs_pkg::op_none) begin
          state <= ccs_pkg::st_exec;
          cur   <= dec;
        end else begin
          state <= ccs_pkg::st_idle;
        end
      end
    end else if (q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec && take_skip) begin
      skip_left <= next_two_word ? `CCS_SKIP_TWO : `CCS_SKIP_ONE;
    end
  end

  // register read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr     <= `CCS_ADDR_RESET;
      mem_rd       <= 1'b0;
      indexed_mode <= 1'b0;
    end else if (q == `CCS_Q_READ && state == ccs_pkg::st_exec) begin
      mem_addr     <= res_addr;
      indexed_mode <= res_indexed;
      mem_rd       <= 1'b1;
    end else begin
      mem_rd <= 1'b0;
    end
  end

  // complement and write-back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result  <= `CCS_DATA_RESET;
      mem_wr  <= 1'b0;
      wreg_wr <= 1'b0;
      flags   <= '0;
    end else if (q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
                 cur.op == ccs_pkg::complement_register_op) begin
      result  <= ~mem_rdata;
      mem_wr  <= cur.dest;
      wreg_wr <= !cur.dest;
      flags   <= '{wr: 1'b1, n: ~mem_rdata[7], z: (mem_rdata == 8'hff)};
    end else begin
      mem_wr  <= 1'b0;
      wreg_wr <= 1'b0;
      flags.wr <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  comp_result_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op == ccs_pkg::complement_register_op
    |=> (mem_wr || wreg_wr) && result == ~$past(mem_rdata))
    else $error("complement result wrong");

  dest_select_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op == ccs_pkg::complement_register_op
    |=> mem_wr == $past(cur.dest) && wreg_wr == !$past(cur.dest))
    else $error("destination select wrong");

  bank_select_a: assert property (
    q == `CCS_Q_READ && state == ccs_pkg::st_exec && cur.access
    |=> mem_rd && mem_addr == {$past(bank_pointer_register), $past(cur.field)})
    else $error("banked address wrong");

  indexed_addr_a: assert property (
    q == `CCS_Q_READ && state == ccs_pkg::st_exec
    |=> indexed_mode == (!$past(cur.access) && $past(ext_set_enable) &&
                         $past(cur.field) <= `CCS_IDX_LIMIT))
    else $error("indexed mode select wrong");

  cmp_no_flags_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op != ccs_pkg::complement_register_op
    |=> !flags.wr && !mem_wr && !wreg_wr)
    else $error("compare touched flags or data");

  skip_one_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op == ccs_pkg::compare_skip_equal_op && mem_rdata == wreg_in && !next_two_word
    |-> ##3 nop_cycle [*4] ##1 !nop_cycle)
    else $error("single skip length wrong");

  skip_two_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec && take_skip && next_two_word
    |-> ##3 nop_cycle [*8] ##1 !nop_cycle)
    else $error("double skip length wrong");

  skip_greater_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op == ccs_pkg::compare_skip_greater_op
    |=> (skip_left != `CCS_SKIP_NONE) == ($past(mem_rdata) > $past(wreg_in)))
    else $error("greater skip decision wrong");

  skip_less_a: assert property (
    q == `CCS_Q_PROCESS && state == ccs_pkg::st_exec &&
    cur.op == ccs_pkg::compare_skip_less_op
    |=> (skip_left != `CCS_SKIP_NONE) == ($past(mem_rdata) < $past(wreg_in)))
    else $error("less skip decision wrong");

  comp_flags_a: assert property (
    flags.wr |-> q == `CCS_Q_WRITE && flags.n == result[7] &&
                 flags.z == (result == 8'h00))
    else $error("complement flags wrong");

  indexed_base_a: assert property (
    q == `CCS_Q_READ && state == ccs_pkg::st_exec && res_indexed
    |=> mem_addr == 12'($past(index_base) + {4'h0, $past(cur.field)}))
    else $error("indexed address wrong");

  access_bank_a: assert property (
    q == `CCS_Q_READ && state == ccs_pkg::st_exec && !cur.access && !res_indexed
    |=> mem_addr[7:0] == $past(cur.field) &&
        mem_addr[11:8] == (($past(cur.field) < `CCS_ACC_SPLIT) ?
                           `CCS_ACC_LOW_BANK : `CCS_ACC_HI_BANK))
    else $error("access bank address wrong");

  skip_quiet_a: assert property (
    nop_cycle |-> !mem_rd && !mem_wr && !wreg_wr)
    else $error("skipped cycle not quiet");

endmodule

// File: tb/ccs_mem_model.sv
`timescale 1ns/1ns

module ccs_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  result,
  output wire logic [7:0]  mem_rdata
);
  logic [7:0] mem [0:4095];

  // read data stands while mem_rd is high, the inverse otherwise
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= result;
    end
  end
endmodule

// File: tb/complement_compare_skip_exec_bench.sv
`timescale 1ns/1ns

module complement_compare_skip_exec_bench;
  logic                clk;
  logic                rst_n;
  logic                instr_valid;
  logic [15:0]         instr;
  logic                next_two_word;
  logic                ext_set_enable;
  logic [3:0]          bank;
  logic [11:0]         index_base;
  logic [7:0]          wreg_in;
  logic [7:0]          mem_rdata;
  logic [1:0]          q_phase;
  logic [11:0]         mem_addr;
  logic                mem_rd;
  logic                mem_wr;
  logic                wreg_wr;
  logic [7:0]          result;
  ccs_pkg::ccs_flags_t flags;
  logic                nop_cycle;
  logic                indexed_mode;
  int                  errors;
  int                  checked;

  ccs_exec ccs_exec_i (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .next_two_word(next_two_word), .ext_set_enable(ext_set_enable),
    .bank_pointer_register(bank), .index_base(index_base), .wreg_in(wreg_in),
    .mem_rdata(mem_rdata), .q_phase(q_phase), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .wreg_wr(wreg_wr), .result(result), .flags(flags),
    .nop_cycle(nop_cycle), .indexed_mode(indexed_mode));

  ccs_mem_model ccs_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .result(result), .mem_rdata(mem_rdata));

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic [15:0] w, input logic [7:0] wv, input logic two,
    input logic [3:0] bk, input logic ext, input logic [11:0] ea, input logic ewm,
    input logic eww, input logic [7:0] er, input int en);
    int n;
    n = 0;
    repeat (8) if (q_phase !== 2'h0) @(negedge clk);
    instr = w;
    instr_valid = 1'b1;
    wreg_in = wv;
    next_two_word = two;
    bank = bk;
    ext_set_enable = ext;
    @(negedge clk);
    instr_valid = 1'b0;
    @(negedge clk);
    chk("rd", 12'h001, {11'h0, mem_rd});
    chk("addr", ea, mem_addr);
    chk("indexed", {11'h0, ext & ~w[8] & (w[7:0] <= 8'h5f)}, {11'h0, indexed_mode});
    @(negedge clk);
    chk("mem_wr", {11'h0, ewm}, {11'h0, mem_wr});
    chk("wreg_wr", {11'h0, eww}, {11'h0, wreg_wr});
    chk("flag_wr", {11'h0, ewm | eww}, {11'h0, flags.wr});
    if (ewm | eww) begin
      chk("result", {4'h0, er}, {4'h0, result});
      chk("nz", {10'h0, er[7], er == 8'h00}, {10'h0, flags.n, flags.z});
    end
    instr = 16'h1c00;
    instr_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      repeat (4) @(negedge clk);
      if (nop_cycle === 1'b1) begin
        n++;
        chk("nop_wr", 12'h000, {10'h0, mem_wr, wreg_wr});
      end else begin
        chk("fill_wr", 12'h001, {11'h0, wreg_wr});
      end
      chk("nop_slot", {11'h0, i < en}, {11'h0, nop_cycle});
    end
    instr_valid = 1'b0;
    chk("nops", en[11:0], n[11:0]);
    $display("test %h done", w);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #8000;
    errors++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    next_two_word = 1'b0;
    ext_set_enable = 1'b0;
    bank = 4'h0;
    index_base = 12'h200;
    wreg_in = 8'h00;
    errors = 0;
    checked = 0;
    ccs_mem_model_i.mem[12'h321] = 8'h13;
    ccs_mem_model_i.mem[12'hf70] = 8'hff;
    ccs_mem_model_i.mem[12'h25f] = 8'h80;
    ccs_mem_model_i.mem[12'h05f] = 8'h00;
    ccs_mem_model_i.mem[12'h310] = 8'h00;
    ccs_mem_model_i.mem[12'h340] = 8'h55;
    ccs_mem_model_i.mem[12'h000] = 8'h00;
    ccs_mem_model_i.mem[12'h200] = 8'h00;
    ccs_mem_model_i.mem[12'hfe0] = 8'h00;
    ccs_mem_model_i.mem[12'h03f] = 8'h3c;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    run(16'h1f21, 8'h00, 0, 4'h3, 0, 12'h321, 1, 0, 8'hec, 0);
    run(16'h1c70, 8'h00, 0, 4'h3, 1, 12'hf70, 0, 1, 8'h00, 0);
    run(16'h1c5f, 8'h00, 0, 4'h3, 1, 12'h25f, 0, 1, 8'h7f, 0);
    run(16'h1c5f, 8'h00, 0, 4'h3, 0, 12'h05f, 0, 1, 8'hff, 0);
    index_base = 12'hfe0;
    run(16'h1c5f, 8'h00, 0, 4'h3, 1, 12'h03f, 0, 1, 8'hc3, 0);
    run(16'h1d10, 8'h00, 0, 4'h3, 1, 12'h310, 0, 1, 8'hff, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("q_rst", 12'h000, {10'h0, q_phase});
    chk("addr_rst", 12'h000, mem_addr);
    chk("res_rst", 12'h000, {1'b0, flags, result});
    chk("pulse_rst", 12'h000, {7'h0, mem_rd, mem_wr, wreg_wr, nop_cycle, indexed_mode});
    rst_n = 1'b1;
    @(negedge clk);
    chk("q_run", 12'h001, {10'h0, q_phase});
    $display("test reset done");
    run(16'h6340, 8'h55, 0, 4'h3, 0, 12'h340, 0, 0, 8'h00, 1);
    run(16'h6340, 8'h55, 1, 4'h3, 0, 12'h340, 0, 0, 8'h00, 2);
    run(16'h6340, 8'h54, 1, 4'h3, 0, 12'h340, 0, 0, 8'h00, 0);
    run(16'h6540, 8'h54, 0, 4'h3, 0, 12'h340, 0, 0, 8'h00, 1);
    run(16'h6540, 8'haa, 0, 4'h3, 0, 12'h340, 0, 0, 8'h00, 0);
    run(16'h6140, 8'haa, 1, 4'h3, 0, 12'h340, 0, 0, 8'h00, 2);
    run(16'h6140, 8'h55, 0, 4'h3, 0, 12'h340, 0, 0, 8'h00, 0);
    finish_test;
  end
endmodule
